// *** inc/pio_pkg.sv ***
package pio_pkg;
    localparam int unsigned  ADDR_W       = 16;
    localparam int unsigned  DATA_W       = 8;
    localparam int unsigned  PORT_W       = 32;
    localparam int unsigned  JMP_W        = 8;
    // Fixed decode: A15..A13 = 100, A11..A9 = 111
    localparam logic [2:0]   HI_FIXED     = 3'h4;
    localparam logic [2:0]   MID_FIXED    = 3'h7;
    localparam int unsigned  HI_LSB       = 13;
    localparam int unsigned  MID_LSB      = 9;
    localparam int unsigned  JBANK_BIT    = 12;
    localparam int unsigned  JLOW_LSB     = 2;
    localparam int unsigned  JLOW_MSB     = 8;
    localparam logic [31:0]  OUT_RST      = 32'h0000_0000;
    localparam logic [7:0]   RDATA_RST    = 8'h00;
    localparam logic [7:0]   JMP_NONE     = 8'hFF;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              rnw;
        logic              strobe;
        logic              phi2;
    } pio_bus_s;
endpackage

// *** design/pio_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pio_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,    // Clock
    input  wire logic         rst_n,  // Async reset, active low
    input  wire logic [W-1:0] d,      // Asynchronous input
    output logic      [W-1:0] q       // Synchronised output
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pio_sync_s;
    pio_sync_s st_reg;
    pio_sync_s st_next;
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign q = st_reg.s2;
endmodule
`default_nettype wire

// *** design/pio_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pio_top #(
    parameter int unsigned ADDR_W = pio_pkg::ADDR_W, // Bus address width
    parameter int unsigned DATA_W = pio_pkg::DATA_W, // Bus data width
    parameter int unsigned PORT_W = pio_pkg::PORT_W, // Parallel port width
    parameter int unsigned JMP_W  = pio_pkg::JMP_W   // Jumper count
) (
    input  wire logic              CLK,                        // 10 MHz clock
    input  wire logic              RESETN,                     // Async reset, active low
    input  wire logic [ADDR_W-1:0] ADDR,                       // Bus address
    input  wire logic [DATA_W-1:0] DATA_IN,                    // Bus data in
    output logic      [DATA_W-1:0] DATA_OUT,                   // Bus data out, registered
    output logic                   DATA_OE,                    // Data bus drive enable
    input  wire logic              RNW,                        // High for read
    input  wire logic              VALID_MEMORY_ACCESS_STROBE, // Valid access
    input  wire logic              PHI2,                       // Phase-two bus clock
    input  wire logic [JMP_W-1:0]  JUMPER_N,                   // Jumpers, low when fitted
    input  wire logic [PORT_W-1:0] PAR_IN,                     // External inputs
    output logic      [PORT_W-1:0] PAR_OUT                     // Latched outputs
);
    localparam int unsigned SW    = ADDR_W + DATA_W + 3;
    localparam int unsigned LANES = PORT_W / DATA_W;

    // Decode and byte lanes are fixed by the bus, so other widths cannot be served
    if (ADDR_W != 16) begin : g_bad_addr
        $error("pio_top: ADDR_W must be 16");
    end
    if (DATA_W != 8) begin : g_bad_data
        $error("pio_top: DATA_W must be 8");
    end
    if (LANES != 4 || PORT_W != LANES * DATA_W) begin : g_bad_port
        $error("pio_top: PORT_W must be four bytes");
    end
    if (JMP_W != 8) begin : g_bad_jmp
        $error("pio_top: JMP_W must be 8");
    end
    if (SW != $bits(pio_pkg::pio_bus_s)) begin : g_bad_bus
        $error("pio_top: bus bundle width mismatch");
    end

    pio_pkg::pio_bus_s  bus_raw;
    pio_pkg::pio_bus_s  bus;
    logic [SW-1:0]      bus_q;
    logic [JMP_W-1:0]   jmp;
    logic [PORT_W-1:0]  pin;
    logic               sel;
    logic [1:0]         bsel;
    logic               rd_hit;
    logic               wr_hit;
    logic               wr_strobe;

    typedef struct packed {
        logic                phi2_d;
        logic [PORT_W-1:0]   outl;
        logic [DATA_W-1:0]   rdata;
        logic                oe;
    } pio_top_s;
    pio_top_s st_reg;
    pio_top_s st_next;

    // All bus and pin inputs are asynchronous to CLK
    assign bus_raw = '{addr: ADDR, wdata: DATA_IN, rnw: RNW,
                       strobe: VALID_MEMORY_ACCESS_STROBE, phi2: PHI2};
    // One synchroniser for the whole bus keeps address, data and strobes aligned
    pio_sync #(
        .W(SW)
    ) u_sbus (
        .clk   (CLK),
        .rst_n (RESETN),
        .d     (bus_raw),
        .q     (bus_q)
    );
    pio_sync #(
        .W(JMP_W)
    ) u_sjmp (
        .clk   (CLK),
        .rst_n (RESETN),
        .d     (JUMPER_N),
        .q     (jmp)
    );
    pio_sync #(
        .W(PORT_W)
    ) u_spin (
        .clk   (CLK),
        .rst_n (RESETN),
        .d     (PAR_IN),
        .q     (pin)
    );
    assign bus = pio_pkg::pio_bus_s'(bus_q);

    // Open jumper reads 1, so none fitted decodes 9FFC
    function automatic logic sel_hit(input logic [15:0] a, input logic [7:0] j);
        logic hit;
        hit = (a[15:pio_pkg::HI_LSB] == pio_pkg::HI_FIXED)
            && (a[11:pio_pkg::MID_LSB] == pio_pkg::MID_FIXED)
            && (a[pio_pkg::JBANK_BIT] == j[7])
            && (a[pio_pkg::JLOW_MSB:pio_pkg::JLOW_LSB] == j[6:0]);
        return hit;
    endfunction

    // Byte lane of the port word picked by the two low address bits
    function automatic logic [7:0] lane_get(input logic [31:0] w, input logic [1:0] idx);
        logic [7:0] b;
        b = w[8*idx +: 8];
        return b;
    endfunction

    // Port word with one byte lane replaced, the others untouched
    function automatic logic [31:0] lane_put(input logic [31:0] w, input logic [1:0] idx, input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[8*idx +: 8] = b;
        return r;
    endfunction

    assign sel       = bus.strobe && sel_hit(bus.addr, jmp);
    assign bsel      = bus.addr[1:0];
    assign rd_hit    = sel && bus.rnw && bus.phi2;
    assign wr_hit    = sel && !bus.rnw;
    assign wr_strobe = wr_hit && st_reg.phi2_d && !bus.phi2;

    always_comb begin
        st_next        = st_reg;
        st_next.phi2_d = bus.phi2;
        // Read data driven for the whole phase-two high time
        st_next.oe     = rd_hit;
        if (rd_hit) begin
            st_next.rdata = lane_get(pin, bsel);
        end
        // Write captured on the falling edge of phase two, when data is stable
        if (wr_strobe) begin
            st_next.outl = lane_put(st_reg.outl, bsel, bus.wdata);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= '{phi2_d: 1'b0, outl: pio_pkg::OUT_RST, rdata: pio_pkg::RDATA_RST, oe: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign DATA_OUT = st_reg.rdata;
    assign DATA_OE  = st_reg.oe;
    assign PAR_OUT  = st_reg.outl;

    a_oe_only_read: assert property (@(posedge CLK) disable iff (!RESETN)
        DATA_OE |-> $past(rd_hit))
        else $error("data bus driven outside own read");

    a_out_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        !$past(wr_hit) |-> $stable(PAR_OUT))
        else $error("output latch changed without write");

    a_write_load: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_strobe |=> lane_get(PAR_OUT, $past(bsel)) == $past(bus.wdata))
        else $error("write byte not latched");

    a_read_data: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_hit |=> DATA_OUT == $past(lane_get(pin, bsel)))
        else $error("read byte mismatch");

    a_default_base: assert property (@(posedge CLK) disable iff (!RESETN)
        (jmp == pio_pkg::JMP_NONE && bus.addr == 16'h9FFC && bus.strobe) |-> sel)
        else $error("default base not decoded");

    a_range_only: assert property (@(posedge CLK) disable iff (!RESETN)
        sel |-> (bus.addr[15:9] == {pio_pkg::HI_FIXED, 1'b0, pio_pkg::MID_FIXED}
              || bus.addr[15:9] == {pio_pkg::HI_FIXED, 1'b1, pio_pkg::MID_FIXED}))
        else $error("decode outside ranges");

    a_strobe_needed: assert property (@(posedge CLK) disable iff (!RESETN)
        !bus.strobe |=> !DATA_OE)
        else $error("access without strobe");

    a_other_lanes: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_strobe |=> PAR_OUT == lane_put($past(PAR_OUT), $past(bsel), $past(bus.wdata)))
        else $error("write disturbed another byte");

    a_oe_on_read: assert property (@(posedge CLK) disable iff (!RESETN)
        rd_hit |=> DATA_OE)
        else $error("own read not driven");

    a_read_no_write: assert property (@(posedge CLK) disable iff (!RESETN)
        (sel && bus.rnw) |=> $stable(PAR_OUT))
        else $error("read changed output latch");

    a_miss_no_write: assert property (@(posedge CLK) disable iff (!RESETN)
        !sel |=> $stable(PAR_OUT))
        else $error("unselected access changed latch");

    a_rdata_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        !$past(rd_hit) |-> $stable(DATA_OUT))
        else $error("read byte changed without read");

    a_oe_release: assert property (@(posedge CLK) disable iff (!RESETN)
        !rd_hit |=> !DATA_OE)
        else $error("data bus left driven");

    a_sel_bank: assert property (@(posedge CLK) disable iff (!RESETN)
        sel |-> bus.addr[pio_pkg::JBANK_BIT] == jmp[7])
        else $error("bank bit not compared");

    a_sel_low: assert property (@(posedge CLK) disable iff (!RESETN)
        sel |-> bus.addr[pio_pkg::JLOW_MSB:pio_pkg::JLOW_LSB] == jmp[6:0])
        else $error("low address bits not compared");

    // A latch change must come from a phase-two fall, never from the rise
    a_write_phase: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(PAR_OUT) |-> $past(wr_strobe))
        else $error("latch changed outside phase-two fall");

    // Read data must track the lane of the synchronised inputs while driven
    a_read_lane: assert property (@(posedge CLK) disable iff (!RESETN)
        $past(rd_hit) |-> DATA_OUT == $past(lane_get(pin, bsel)))
        else $error("driven byte not from inputs");
endmodule
`default_nettype wire

// *** tb/pio_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pio_cpu_model (
    input  wire logic          clk,     // Bus clock
    input  wire logic [7:0]    rd_data, // Device read byte
    input  wire logic          rd_oe,   // Device drive enable
    output var pio_pkg::pio_bus_s bus   // Bus toward the device
);
    initial bus = '{addr: 16'h0000, wdata: 8'h00, rnw: 1'b1, strobe: 1'b0, phi2: 1'b0};
    task automatic xfer(input logic rnw, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic oe);
        @(negedge clk);
        bus = '{addr: a, wdata: d, rnw: rnw, strobe: 1'b1, phi2: 1'b1};
        repeat (4) @(negedge clk);
        q = rd_data;
        oe = rd_oe;
        bus.phi2 = 1'b0;
        repeat (4) @(negedge clk);
        // Released bus shows the inverse so a stale value cannot pass as held
        bus = '{addr: ~a, wdata: ~d, rnw: 1'b1, strobe: 1'b0, phi2: 1'b0};
    endtask
endmodule
`default_nettype wire

// *** tb/tb_parallel_io_32in_32out.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_io_32in_32out;
    logic              clk;
    logic              resetn;
    logic [7:0]        jumper_n;
    logic [31:0]       par_in;
    logic [31:0]       par_out;
    logic [7:0]        data_out;
    logic              data_oe;
    logic [7:0]        q;
    logic              oe;
    logic [31:0]       rng;
    logic [31:0]       exp_out;
    logic [15:0]       base;
    logic [15:0]       miss;
    pio_pkg::pio_bus_s bus;
    int                errors = 0;
    int                check_count = 0;
    int                cycles = 0;
    pio_top pio_top_inst (.CLK(clk), .RESETN(resetn), .ADDR(bus.addr), .DATA_IN(bus.wdata), .DATA_OUT(data_out),
        .DATA_OE(data_oe), .RNW(bus.rnw), .VALID_MEMORY_ACCESS_STROBE(bus.strobe), .PHI2(bus.phi2),
        .JUMPER_N(jumper_n), .PAR_IN(par_in), .PAR_OUT(par_out));
    pio_cpu_model pio_cpu_model_inst (.clk(clk), .rd_data(data_out), .rd_oe(data_oe), .bus(bus));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            give_verdict;
        end
    end
    initial begin
        resetn = 1'b0;
        jumper_n = 8'hFF;
        par_in = 32'h0000_0000;
        rng = 32'h898B;
        repeat (10) @(posedge clk);
        chk({39'h0, data_oe}, 40'h0);
        @(negedge clk) resetn = 1'b1;
        for (int n = 0; n < 12; n++) begin
            rng = xs(rng);
            jumper_n = (n == 0) ? 8'hFF : rng[7:0];
            // Open jumpers must land on the delivered address
            base = (n == 0) ? 16'h9FFC : {3'h4, jumper_n[7], 3'h7, jumper_n[6:0], 2'h0};
            for (int b = 0; b < 4; b++) begin
                rng = xs(rng);
                exp_out[8*b +: 8] = rng[7:0];
                pio_cpu_model_inst.xfer(1'b0, base + 16'(b), rng[7:0], q, oe);
            end
            chk({8'h0, par_out}, {8'h0, exp_out});
            for (int m = 0; m < 3; m++) begin
                miss = base ^ ((m == 0) ? 16'h1000 : (m == 1) ? (16'h0004 << (n % 7)) : (16'h0200 << (n % 6)));
                pio_cpu_model_inst.xfer(1'b0, miss, ~rng[7:0], q, oe);
                pio_cpu_model_inst.xfer(1'b1, miss, 8'h00, q, oe);
                chk({7'h0, oe, par_out}, {8'h0, exp_out});
            end
            rng = xs(rng);
            par_in = rng;
            for (int b = 0; b < 4; b++) begin
                pio_cpu_model_inst.xfer(1'b1, base + 16'(b), 8'h00, q, oe);
                chk({31'h0, oe, q}, {31'h0, 1'b1, par_in[8*b +: 8]});
            end
        end
        give_verdict;
    end
endmodule
`default_nettype wire
